// ### design/btr_regs.vh
`ifndef BTR_REGS_VH
`define BTR_REGS_VH

// lane count and synchroniser depth
`define BTR_LANES        9
`define BTR_SYNC_STAGES  2

// one-hot path modes
`define BTR_MODE_W       3
`define BTR_MODE_THRU    3'h1
`define BTR_MODE_LATCH   3'h2
`define BTR_MODE_REG     3'h4

// field positions in the synchronised control word
`define BTR_CTL_W        7
`define BTR_CTL_BP_HI    0
`define BTR_CTL_BP_LO_N  1
`define BTR_CTL_LOGIC_EN 2
`define BTR_CTL_SEL_LSB  3
`define BTR_CTL_SEL_MSB  4
`define BTR_CTL_FWD_STB  5
`define BTR_CTL_REV_STB  6

// reset values
`define BTR_HELD_RST     9'h1ff
`define BTR_LANES_ZERO   9'h000
`define BTR_CTL_RST      7'h02
`define BTR_MODE_RST     3'h2

`endif

// ### design/btr_sync.v
`include "btr_regs.vh"

module btr_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    // clock and reset
    input  wire             clk_sys_i,
    input  wire             reset_i,
    // asynchronous level in, synchronised level out
    input  wire [WIDTH-1:0] async_i,
    output reg  [WIDTH-1:0] sync_o
);

    // first stage feeds only the second stage
    reg [WIDTH-1:0] meta_q;

    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            meta_q <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule // btr_sync

// ### design/btr_path.v
`include "btr_regs.vh"

module btr_path (
    // clock and reset
    input  wire                   clk_sys_i,
    input  wire                   reset_i,
    // mode and capture strobe, already synchronised
    input  wire [`BTR_MODE_W-1:0] mode_i,
    input  wire                   strobe_i,
    // input lanes, already synchronised
    input  wire [`BTR_LANES-1:0]  data_i,
    // inverted held value and capture pulse
    output reg  [`BTR_LANES-1:0]  held_o,
    output reg                    capture_o
);

    reg                  strobe_prev_q;
    reg [`BTR_LANES-1:0] data_prev_q;
    reg [`BTR_LANES-1:0] held_d;
    wire                 rise;

    assign rise = strobe_i & ~strobe_prev_q;

    always @* begin
        held_d = held_o;
        case (mode_i)
            `BTR_MODE_THRU: held_d = ~data_i;
            `BTR_MODE_LATCH: if (!strobe_i) held_d = ~data_i;
            `BTR_MODE_REG: if (rise) held_d = ~data_prev_q;
            default: held_d = held_o;
        endcase
    end

    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            strobe_prev_q <= 1'b0;
            data_prev_q   <= `BTR_LANES_ZERO;
            held_o        <= `BTR_HELD_RST;
            capture_o     <= 1'b0;
        end else begin
            strobe_prev_q <= strobe_i;
            data_prev_q   <= data_i;
            held_o        <= held_d;
            capture_o     <= rise & (mode_i != `BTR_MODE_THRU);
        end
    end

endmodule // btr_path

// ### design/btr_core.v
`include "btr_regs.vh"

module btr_core (
    // clock and reset
    input  wire                  clk_sys_i,
    input  wire                  reset_i,
    // logic side lanes
    input  wire [`BTR_LANES-1:0] logic_side_lanes_i,
    output reg  [`BTR_LANES-1:0] logic_side_lanes_o,
    output reg  [`BTR_LANES-1:0] logic_side_lanes_oe_o,
    // backplane lanes, open collector
    input  wire [`BTR_LANES-1:0] backplane_lanes_i,
    output reg  [`BTR_LANES-1:0] backplane_lanes_o,
    output reg  [`BTR_LANES-1:0] backplane_lanes_oe_o,
    // output enables
    input  wire                  bp_drive_en_hi_i,
    input  wire                  bp_drive_en_lo_n_i,
    input  wire                  logic_side_out_en_i,
    // mode selects
    input  wire                  path_sel_lsb_i,
    input  wire                  path_sel_msb_i,
    // capture strobes
    input  wire                  fwd_capture_strobe_i,
    input  wire                  rev_capture_strobe_i,
    // status
    output reg  [`BTR_MODE_W-1:0] fwd_mode_o,
    output reg  [`BTR_MODE_W-1:0] rev_mode_o,
    output reg                    fwd_capture_o,
    output reg                    rev_capture_o,
    output reg                    mode_change_o,
    output reg                    drive_clash_o
);

    // synchronised pins and the raw control word
    wire [`BTR_LANES-1:0] logic_in_s;
    wire [`BTR_LANES-1:0] bp_in_s;
    wire [`BTR_CTL_W-1:0] ctl_s;
    wire [`BTR_CTL_W-1:0] ctl_raw;

    // decoded controls
    wire                  bp_en;
    wire                  logic_en;
    wire                  sel_lsb;
    wire                  sel_msb;
    wire                  fwd_stb;
    wire                  rev_stb;

    // mode decode
    reg  [`BTR_MODE_W-1:0] fwd_mode_d;
    reg  [`BTR_MODE_W-1:0] rev_mode_d;
    reg  [`BTR_MODE_W-1:0] fwd_mode_q;
    reg  [`BTR_MODE_W-1:0] rev_mode_q;

    // path results
    wire [`BTR_LANES-1:0] fwd_held;
    wire [`BTR_LANES-1:0] rev_held;
    wire                  fwd_cap;
    wire                  rev_cap;

    // output stage next values
    reg  [`BTR_LANES-1:0] bp_oe_d;
    reg  [`BTR_LANES-1:0] logic_d;
    reg  [`BTR_LANES-1:0] logic_oe_d;

    assign ctl_raw[`BTR_CTL_BP_HI]    = bp_drive_en_hi_i;
    assign ctl_raw[`BTR_CTL_BP_LO_N]  = bp_drive_en_lo_n_i;
    assign ctl_raw[`BTR_CTL_LOGIC_EN] = logic_side_out_en_i;
    assign ctl_raw[`BTR_CTL_SEL_LSB]  = path_sel_lsb_i;
    assign ctl_raw[`BTR_CTL_SEL_MSB]  = path_sel_msb_i;
    assign ctl_raw[`BTR_CTL_FWD_STB]  = fwd_capture_strobe_i;
    assign ctl_raw[`BTR_CTL_REV_STB]  = rev_capture_strobe_i;

    // data and controls share one depth so strobes line up with data
    btr_sync #(
        .WIDTH   (`BTR_LANES),
        .RST_VAL (`BTR_LANES_ZERO)
    ) u_sync_logic (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .async_i   (logic_side_lanes_i),
        .sync_o    (logic_in_s)
    );

    // floating lanes resolve low at the pin
    btr_sync #(
        .WIDTH   (`BTR_LANES),
        .RST_VAL (`BTR_LANES_ZERO)
    ) u_sync_bp (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .async_i   (backplane_lanes_i),
        .sync_o    (bp_in_s)
    );

    // reset value keeps backplane drivers off
    btr_sync #(
        .WIDTH   (`BTR_CTL_W),
        .RST_VAL (`BTR_CTL_RST)
    ) u_sync_ctl (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .async_i   (ctl_raw),
        .sync_o    (ctl_s)
    );

    assign bp_en    = ctl_s[`BTR_CTL_BP_HI] & ~ctl_s[`BTR_CTL_BP_LO_N];
    assign logic_en = ctl_s[`BTR_CTL_LOGIC_EN];
    assign sel_lsb  = ctl_s[`BTR_CTL_SEL_LSB];
    assign sel_msb  = ctl_s[`BTR_CTL_SEL_MSB];
    assign fwd_stb  = ctl_s[`BTR_CTL_FWD_STB];
    assign rev_stb  = ctl_s[`BTR_CTL_REV_STB];

    always @* begin
        fwd_mode_d = `BTR_MODE_LATCH;
        case ({sel_lsb, sel_msb})
            2'h2: fwd_mode_d = `BTR_MODE_THRU;
            2'h1: fwd_mode_d = `BTR_MODE_REG;
            2'h3: fwd_mode_d = `BTR_MODE_REG;
            2'h0: fwd_mode_d = `BTR_MODE_LATCH;
            default: fwd_mode_d = `BTR_MODE_LATCH;
        endcase
    end

    always @* begin
        rev_mode_d = `BTR_MODE_LATCH;
        case ({sel_lsb, sel_msb})
            2'h2: rev_mode_d = `BTR_MODE_THRU;
            2'h1: rev_mode_d = `BTR_MODE_REG;
            2'h3: rev_mode_d = `BTR_MODE_LATCH;
            2'h0: rev_mode_d = `BTR_MODE_LATCH;
            default: rev_mode_d = `BTR_MODE_LATCH;
        endcase
    end

    // decode is used straight, not from the registered copy,
    // so mode and data stay aligned in the same cycle
    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            fwd_mode_q <= `BTR_MODE_RST;
            rev_mode_q <= `BTR_MODE_RST;
        end else begin
            fwd_mode_q <= fwd_mode_d;
            rev_mode_q <= rev_mode_d;
        end
    end

    // set-up assumed; sample one cycle before edge
    btr_path u_fwd (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .mode_i    (fwd_mode_d),
        .strobe_i  (fwd_stb),
        .data_i    (logic_in_s),
        .held_o    (fwd_held),
        .capture_o (fwd_cap)
    );

    btr_path u_rev (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .mode_i    (rev_mode_d),
        .strobe_i  (rev_stb),
        .data_i    (bp_in_s),
        .held_o    (rev_held),
        .capture_o (rev_cap)
    );

    // per lane output stage
    genvar g;
    generate
        for (g = 0; g < `BTR_LANES; g = g + 1) begin : g_lane
            always @* begin
                bp_oe_d[g] = bp_en & ~fwd_held[g];
                logic_d[g] = rev_held[g];
                logic_oe_d[g] = logic_en;
            end
        end
    endgenerate

    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            backplane_lanes_o     <= `BTR_LANES_ZERO;
            backplane_lanes_oe_o  <= `BTR_LANES_ZERO;
            logic_side_lanes_o    <= `BTR_LANES_ZERO;
            logic_side_lanes_oe_o <= `BTR_LANES_ZERO;
        end else begin
            // open collector: the data bit only ever pulls low
            backplane_lanes_o     <= `BTR_LANES_ZERO;
            backplane_lanes_oe_o  <= bp_oe_d;
            logic_side_lanes_o    <= logic_d;
            logic_side_lanes_oe_o <= logic_oe_d;
        end
    end

    // status; clash flags a controller slip, it does not gate drivers
    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            fwd_mode_o    <= `BTR_MODE_RST;
            rev_mode_o    <= `BTR_MODE_RST;
            fwd_capture_o <= 1'b0;
            rev_capture_o <= 1'b0;
            mode_change_o <= 1'b0;
            drive_clash_o <= 1'b0;
        end else begin
            fwd_mode_o    <= fwd_mode_q;
            rev_mode_o    <= rev_mode_q;
            fwd_capture_o <= fwd_cap;
            rev_capture_o <= rev_cap;
            mode_change_o <= (fwd_mode_q != fwd_mode_d) | (rev_mode_q != rev_mode_d);
            drive_clash_o <= bp_en & logic_en;
        end
    end

endmodule // btr_core

// ### bench/btr_bus_model.sv
module btr_bus_model (
    // device drives
    input  wire logic [8:0] bp_oe_i,
    input  wire logic [8:0] bp_o_i,
    input  wire logic [8:0] lg_oe_i,
    input  wire logic [8:0] lg_o_i,
    // far-side parties
    input  wire logic [8:0] pull_i,
    input  wire logic       float_i,
    input  wire logic [8:0] host_i,
    // resolved wires
    output wire logic [8:0] bp_lvl_o,
    output wire logic [8:0] lg_lvl_o
);
    timeunit 1ns;
    timeprecision 1ps;
    assign bp_lvl_o = float_i ? 9'h000 : ~((bp_oe_i & ~bp_o_i) | pull_i);
    assign lg_lvl_o = (lg_oe_i & lg_o_i) | (~lg_oe_i & host_i);
endmodule // btr_bus_model

// ### bench/btr_core_chk.sv
module btr_core_chk (
    input wire logic       clk_sys_i,
    input wire logic       reset_i,
    input wire logic [8:0] logic_side_lanes_i,
    input wire logic [8:0] logic_side_lanes_o,
    input wire logic [8:0] logic_side_lanes_oe_o,
    input wire logic [8:0] backplane_lanes_i,
    input wire logic [8:0] backplane_lanes_o,
    input wire logic [8:0] backplane_lanes_oe_o,
    input wire logic       bp_drive_en_hi_i,
    input wire logic       bp_drive_en_lo_n_i,
    input wire logic       logic_side_out_en_i,
    input wire logic       path_sel_lsb_i,
    input wire logic       path_sel_msb_i,
    input wire logic       fwd_capture_strobe_i,
    input wire logic       rev_capture_strobe_i
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    wire bp_en = bp_drive_en_hi_i & ~bp_drive_en_lo_n_i;
    wire thru  = path_sel_lsb_i & ~path_sel_msb_i;
    sequence s_fwd_thru;
        (thru && bp_en && $stable(logic_side_lanes_i))[*8];
    endsequence
    sequence s_rev_thru;
        (thru && $stable(backplane_lanes_i))[*8];
    endsequence
    sequence s_fwd_closed;
        (!path_sel_lsb_i && !path_sel_msb_i && fwd_capture_strobe_i && bp_en)[*8];
    endsequence
    a_bp_never_high: assert property (backplane_lanes_o == 9'h000)
        else $error("backplane driven high");
    a_bp_gate_off: assert property ((!bp_en)[*5] |-> backplane_lanes_oe_o == 9'h000)
        else $error("backplane drives while disabled");
    a_logic_oe: assert property ($stable(logic_side_out_en_i)[*5] |->
        logic_side_lanes_oe_o == {9{logic_side_out_en_i}})
        else $error("logic enable wrong");
    a_fwd_thru_inv: assert property (s_fwd_thru |-> backplane_lanes_oe_o == logic_side_lanes_i)
        else $error("forward thru not inverted");
    a_rev_thru_inv: assert property (s_rev_thru |-> logic_side_lanes_o == ~backplane_lanes_i)
        else $error("reverse thru not inverted");
    a_fwd_latch_hold: assert property (s_fwd_closed |-> $stable(backplane_lanes_oe_o))
        else $error("forward latch leaks");
    a_rev_latch_hold: assert property (((path_sel_lsb_i == path_sel_msb_i) && rev_capture_strobe_i)[*8]
        |-> $stable(logic_side_lanes_o))
        else $error("reverse latch leaks");
    a_fwd_reg_hold: assert property ((path_sel_msb_i && bp_en && $stable(fwd_capture_strobe_i))[*8]
        |-> $stable(backplane_lanes_oe_o))
        else $error("forward register changed without edge");
    a_rev_reg_hold: assert property ((!path_sel_lsb_i && path_sel_msb_i && $stable(rev_capture_strobe_i))[*8]
        |-> $stable(logic_side_lanes_o))
        else $error("reverse register changed without edge");
endmodule // btr_core_chk
bind btr_core btr_core_chk u_chk (.*);

// ### bench/btr_core_tb.sv
module btr_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_sys_i = 1'b0;
    logic       reset_i   = 1'b1;
    logic       en_hi     = 1'b1;
    logic       en_lo_n   = 1'b0;
    logic       lg_en     = 1'b0;
    logic       sel_lsb   = 1'b0;
    logic       sel_msb   = 1'b0;
    logic       fwd_stb   = 1'b0;
    logic       rev_stb   = 1'b0;
    logic       flt       = 1'b0;
    logic [8:0] host      = 9'h000;
    logic [8:0] pull      = 9'h000;
    logic [8:0] prev      = 9'h10f;
    logic [8:0] pat [4]   = '{9'h0a5, 9'h15a, 9'h1ff, 9'h000};
    wire  [8:0] lg_i, lg_o, lg_oe, bp_i, bp_o, bp_oe;
    wire  [2:0] fmode, rmode;
    wire        fcap, rcap, mchg, clash;
    logic [8:0] n_fcap    = 9'h000;
    logic [8:0] n_rcap    = 9'h000;
    int         failures  = 0;
    int         n_tests   = 0;

    btr_core u_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .logic_side_lanes_i(lg_i),
        .logic_side_lanes_o(lg_o), .logic_side_lanes_oe_o(lg_oe), .backplane_lanes_i(bp_i),
        .backplane_lanes_o(bp_o), .backplane_lanes_oe_o(bp_oe), .bp_drive_en_hi_i(en_hi),
        .bp_drive_en_lo_n_i(en_lo_n), .logic_side_out_en_i(lg_en), .path_sel_lsb_i(sel_lsb),
        .path_sel_msb_i(sel_msb), .fwd_capture_strobe_i(fwd_stb), .rev_capture_strobe_i(rev_stb),
        .fwd_mode_o(fmode), .rev_mode_o(rmode), .fwd_capture_o(fcap), .rev_capture_o(rcap),
        .mode_change_o(mchg), .drive_clash_o(clash));
    btr_bus_model u_bus (.bp_oe_i(bp_oe), .bp_o_i(bp_o), .lg_oe_i(lg_oe), .lg_o_i(lg_o),
        .pull_i(pull), .float_i(flt), .host_i(host), .bp_lvl_o(bp_i), .lg_lvl_o(lg_i));

    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // capture pulses stand one cycle, so count them as they pass
    always @(posedge clk_sys_i) begin
        if (fcap)
            n_fcap <= n_fcap + 9'h001;
        if (rcap)
            n_rcap <= n_rcap + 9'h001;
    end

    // inputs settle well before any strobe edge
    task automatic settle;
        repeat (10) @(negedge clk_sys_i);
    endtask
    task automatic mode(input logic l, input logic m);
        sel_lsb = l;
        sel_msb = m;
        settle;
    endtask
    task automatic cmp9(input string nm, input logic [8:0] exp, input logic [8:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge clk_sys_i);
        failures++;
        complete_run;
    end

    initial begin
        repeat (3) @(negedge clk_sys_i);
        reset_i = 1'b0;
        mode(1'b1, 1'b0);
        cmp9("fwd_mode", {6'h00, 3'h1}, {6'h00, fmode});
        cmp9("rev_mode", {6'h00, 3'h1}, {6'h00, rmode});
        cmp9("mode_chg", 9'h000, {8'h00, mchg});
        foreach (pat[i]) begin
            host = pat[i];
            settle;
            cmp9("bp_oe", pat[i], bp_oe);
            cmp9("bp_lvl", ~pat[i], bp_i);
        end
        host = 9'h1ff;
        for (int k = 0; k < 4; k++) begin
            {en_hi, en_lo_n} = k[1:0];
            settle;
            cmp9("bp_gate", (k == 2) ? 9'h1ff : 9'h000, bp_oe);
        end
        {en_hi, en_lo_n} = 2'b10;
        mode(1'b0, 1'b0);
        host = 9'h0f0;
        settle;
        cmp9("fwd_open", 9'h0f0, bp_oe);
        fwd_stb = 1'b1;
        settle;
        host = 9'h10f;
        settle;
        cmp9("fwd_closed", 9'h0f0, bp_oe);
        for (int k = 0; k < 2; k++) begin
            fwd_stb = 1'b0;
            settle;
            mode(k[0], 1'b1);
            host = k[0] ? 9'h0cc : 9'h033;
            settle;
            cmp9("fwd_reg_wait", prev, bp_oe);
            fwd_stb = 1'b1;
            settle;
            prev = host;
            host = ~host;
            settle;
            cmp9("fwd_reg", prev, bp_oe);
        end
        {en_hi, en_lo_n} = 2'b01;
        lg_en = 1'b1;
        mode(1'b1, 1'b0);
        pull = 9'h0c3;
        settle;
        cmp9("rev_thru", 9'h0c3, lg_o);
        cmp9("lg_oe_on", 9'h1ff, lg_oe);
        cmp9("clash", 9'h000, {8'h00, clash});
        flt = 1'b1;
        settle;
        cmp9("rev_float", 9'h1ff, lg_o);
        flt = 1'b0;
        for (int k = 0; k < 2; k++) begin
            rev_stb = 1'b0;
            mode(k[0], k[0]);
            pull = {8'h2a, k[0]};
            settle;
            cmp9("rev_open", {8'h2a, k[0]}, lg_o);
            rev_stb = 1'b1;
            settle;
            pull = 9'h1aa;
            settle;
            cmp9("rev_closed", {8'h2a, k[0]}, lg_o);
        end
        rev_stb = 1'b0;
        mode(1'b0, 1'b1);
        lg_en = 1'b0;
        pull = 9'h137;
        settle;
        rev_stb = 1'b1;
        settle;
        cmp9("lg_oe_off", 9'h000, lg_oe);
        pull = 9'h0c8;
        lg_en = 1'b1;
        settle;
        cmp9("rev_reg", 9'h137, lg_o);
        cmp9("rev_mode_reg", {6'h00, 3'h4}, {6'h00, rmode});
        cmp9("fwd_caps", 9'h003, n_fcap);
        cmp9("rev_caps", 9'h003, n_rcap);
        complete_run;
    end
endmodule // btr_core_tb
